// ===== spb_pkg.sv
// shared constants for the synchronous peripheral bus cycle and its far end
package spb_pkg;
    localparam int ADDR_W = 24; // address bus width
    localparam int DATA_W = 16; // data bus width
    localparam int FC_W = 3; // function code width
    localparam int CNT_W = 4; // phase divider counter width
    localparam logic [CNT_W-1:0] PHASE_LOW_CLKS = 4'h6; // system clocks low per phase period
    localparam logic [CNT_W-1:0] PHASE_HIGH_CLKS = 4'h4; // system clocks high per phase period
    localparam logic [CNT_W-1:0] PHASE_LAST = PHASE_LOW_CLKS + PHASE_HIGH_CLKS - 4'h1;
    localparam logic [CNT_W-1:0] PHASE_RISE_CNT = PHASE_LOW_CLKS - 4'h1; // count before rising
    localparam logic [CNT_W-1:0] SYNC_LAST_CNT = PHASE_LOW_CLKS - 4'h2; // latest select count
    localparam logic [CNT_W-1:0] ALIGN_CNT = PHASE_LAST - 4'h2; // count that starts s5
    localparam logic [CNT_W-1:0] CNT_RESET = 4'h0; // divider value after reset
    localparam logic [ADDR_W-1:0] SYNC_REGION_MASK = 24'hff0000; // decoded address bits
    localparam logic [ADDR_W-1:0] SYNC_REGION_BASE = 24'hff0000; // synchronous region
    localparam int MEM_DEPTH = 16; // words held by the peripheral model end
    localparam int MEM_IDX_W = 4; // index bits into that memory
    localparam int MEM_IDX_LSB = 1; // word address starts above byte bit
    localparam logic [DATA_W-1:0] DATA_IDLE = 16'hffff; // level of an undriven data bus
endpackage

// ===== spb_if.sv
// pins between the processor bus end and the synchronous peripheral end
`timescale 1ns/1ps
interface spb_if;
    import spb_pkg::*;
    logic [ADDR_W-1:0] addr; // address lines
    logic addr_oe; // processor drives the address
    logic [FC_W-1:0] fc; // function code
    logic fc_oe; // processor drives the function code
    logic [DATA_W-1:0] cpu_data; // processor data out
    logic cpu_data_oe; // processor drives data
    logic [DATA_W-1:0] per_data; // peripheral data out
    logic per_data_oe; // peripheral drives data
    logic [DATA_W-1:0] data_bus; // resolved data level
    logic rw_n; // high read, low write
    logic address_valid_strobe_n; // address strobe
    logic upper_byte_strobe_n; // upper data strobe
    logic lower_byte_strobe_n; // lower data strobe
    logic sync_device_request_n; // request from decode
    logic async_transfer_ack_n; // asynchronous acknowledge
    logic valid_peripheral_select_n; // select from the processor
    logic phase_clk; // slow peripheral phase clock
    // data bus resolution; the idle level stands in for the pull-ups
    assign data_bus = cpu_data_oe ? cpu_data : (per_data_oe ? per_data : DATA_IDLE);
    modport cpu (
        output addr, addr_oe, fc, fc_oe, cpu_data, cpu_data_oe, rw_n,
        output address_valid_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n,
        output valid_peripheral_select_n, phase_clk,
        input data_bus, sync_device_request_n, async_transfer_ack_n
    );
    modport per (
        output per_data, per_data_oe, sync_device_request_n, async_transfer_ack_n,
        input addr, addr_oe, data_bus, rw_n, address_valid_strobe_n,
        input upper_byte_strobe_n, lower_byte_strobe_n, valid_peripheral_select_n, phase_clk
    );
endinterface

// ===== spb_ext_select.sv
// two-stage external select generator for processors without a select pin
`timescale 1ns/1ps
module spb_ext_select
    import spb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic i_sync_decode_hit, // decode true with strobe and address match
    input wire logic i_phase_clk, // peripheral phase clock
    output logic o_ext_select // active-high select
);
    logic phase_prev_reg; // phase clock one clock ago, for falling-edge detect
    logic stage1_reg; // first stage, set at phase fall
    logic stage2_reg; // second stage, the select itself

    // remember the phase clock to spot its falling edge
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            phase_prev_reg <= 1'b0;
        end else if (i_ce) begin
            phase_prev_reg <= i_phase_clk;
        end
    end

    // first stage sets on the phase fall while the decode holds
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            stage1_reg <= 1'b0;
        end else if (i_ce) begin
            if (!i_sync_decode_hit) begin
                stage1_reg <= 1'b0; // decode gone: clear
            end else if (phase_prev_reg && !i_phase_clk) begin
                stage1_reg <= 1'b1;
            end
        end
    end

    // second stage follows a clock later and drops the clock after decode negates
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            stage2_reg <= 1'b0;
        end else if (i_ce) begin
            stage2_reg <= stage1_reg && i_sync_decode_hit;
        end
    end

    assign o_ext_select = stage2_reg;
endmodule // spb_ext_select

// ===== spb_peripheral_end.sv
// far end: address decode, request generation and a small synchronous peripheral
`timescale 1ns/1ps
module spb_peripheral_end
    import spb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    spb_if.per bus,
    input wire logic i_use_ext_select, // high: use the locally built select
    output logic o_selected, // level: a peripheral is selected now
    output logic o_write_seen // pulse: a word or a single byte lane was written this clock
);
    logic [DATA_W-1:0] mem [MEM_DEPTH]; // peripheral registers
    logic [DATA_W-1:0] rdata_reg; // read data launched from a flop
    logic sync_decode_hit; // active-high decode
    logic ext_select; // select from the two-stage circuit
    logic sel_active; // select actually in use
    logic strobe_any; // either data strobe asserted
    logic [MEM_IDX_W-1:0] idx; // word index
    logic write_now; // write transfer in this clock

    // decode of the synchronous region, qualified by the address strobe
    assign sync_decode_hit = !bus.address_valid_strobe_n && bus.addr_oe
        && ((bus.addr & SYNC_REGION_MASK) == SYNC_REGION_BASE);
    // combinational, so it falls with the strobe, well within one clock
    assign bus.sync_device_request_n = !sync_decode_hit;
    // this end only runs synchronous cycles, so it never acknowledges asynchronously
    assign bus.async_transfer_ack_n = 1'b1;

    spb_ext_select u_ext_select (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_sync_decode_hit(sync_decode_hit),
        .i_phase_clk(bus.phase_clk),
        .o_ext_select(ext_select)
    );

    // chip select uses the valid-peripheral select, or the external select when i_use_ext_select is high; transfer only while phase is high
    assign sel_active = sync_decode_hit
        && (i_use_ext_select ? ext_select : !bus.valid_peripheral_select_n);
    assign strobe_any = !bus.upper_byte_strobe_n || !bus.lower_byte_strobe_n;
    assign idx = bus.addr[MEM_IDX_LSB +: MEM_IDX_W];
    assign write_now = sel_active && bus.phase_clk && strobe_any && !bus.rw_n;

    // peripheral storage, written per byte lane while phase is high
    always_ff @(posedge i_clk) begin
        if (i_ce && write_now) begin
            if (!bus.upper_byte_strobe_n) begin
                mem[idx][15:8] <= bus.data_bus[15:8];
            end
            if (!bus.lower_byte_strobe_n) begin
                mem[idx][7:0] <= bus.data_bus[7:0];
            end
        end
    end

    // read data held in a flop; word index is stable for the whole cycle
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_reg <= '0;
        end else if (i_ce) begin
            rdata_reg <= mem[idx];
        end
    end

    assign bus.per_data = rdata_reg;
    assign bus.per_data_oe = sel_active && bus.phase_clk && bus.rw_n && strobe_any;
    assign o_selected = sel_active;
    assign o_write_seen = write_now && i_ce;
endmodule // spb_peripheral_end

// ===== spb_cpu_end.sv
// processor end: bus state machine stretching cycles for synchronous peripherals
`timescale 1ns/1ps
// How it works
// - phase clock runs at system clock over ten
// - phase low six clocks, high four clocks
// - select means valid address and phase synchronized
// - s0 function code, s1 address, s2 strobes
// - write: direction low s2, data s3, strobes s4
// - wait states after s4 until request seen
// - after request wait phase low, then select
// - request first recognized in s4
// - select no later than one clock before rise
// - read data latched in s6, phase high
// - strobes negate in s7 as phase falls
// - next clock: address floats, direction high
// - far end drops request within one clock
// - far end never acknowledges with request active
// - far end decodes request from address strobe
// - peripherals select with it, transfer phase high
// - select pin is active low
// - external decode true with strobe and match
// - external select two stages on phase fall
module spb_cpu_end
    import spb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    spb_if.cpu bus,
    input wire logic i_start, // pulse: begin a bus cycle
    input wire logic i_write, // high for a write cycle
    input wire logic [ADDR_W-1:0] i_addr, // cycle address
    input wire logic [FC_W-1:0] i_fc, // cycle function code
    input wire logic [1:0] i_byte_en, // [1] upper lane, [0] lower lane
    input wire logic [DATA_W-1:0] i_wdata, // write data
    output logic o_busy, // level: a cycle is in progress
    output logic o_done, // pulse: cycle finished, read data valid
    output logic o_sync_cycle, // level: last cycle ran synchronously
    output logic [DATA_W-1:0] o_rdata // read data of the last read cycle
);
    typedef enum {
        ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_WAIT, ST_SYNC, ST_ALIGN,
        ST_S5, ST_S6, ST_S7, ST_END
    } bus_state_t;

    bus_state_t state_reg; // current bus state
    bus_state_t state_next; // next bus state
    logic [CNT_W-1:0] cnt_reg; // phase divider count
    logic phase_reg; // phase clock output flop
    logic write_reg; // captured direction of the cycle
    logic [ADDR_W-1:0] addr_reg; // captured address
    logic [FC_W-1:0] fc_reg; // captured function code
    logic [1:0] be_reg; // captured byte lanes
    logic [DATA_W-1:0] wdata_reg; // captured write data
    logic sync_reg; // cycle runs as a synchronous cycle
    logic addr_oe_reg; // address drive enable
    logic fc_oe_reg; // function code drive enable
    logic data_oe_reg; // write data drive enable
    logic rw_n_reg; // direction pin
    logic as_n_reg; // address strobe pin
    logic ds_on_reg; // data strobes asserted
    logic sel_n_reg; // valid-peripheral select pin
    logic [DATA_W-1:0] rdata_reg; // latched read data
    logic done_reg; // completion pulse
    logic req_seen; // request recognized this clock
    logic ack_seen; // asynchronous acknowledge this clock
    logic early_enough; // select can still go out before phase rises

    // phase divider; it never looks at the bus, so sync delay depends on where the request falls in the phase
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_reg <= CNT_RESET;
        end else if (i_ce) begin
            if (cnt_reg == PHASE_LAST) begin
                cnt_reg <= CNT_RESET;
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end

    // phase clock flop: rises after six low clocks, falls after four high ones
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            phase_reg <= 1'b0;
        end else if (i_ce) begin
            if (cnt_reg == PHASE_RISE_CNT) begin
                phase_reg <= 1'b1;
            end else if (cnt_reg == PHASE_LAST) begin
                phase_reg <= 1'b0;
            end
        end
    end

    assign req_seen = !bus.sync_device_request_n;
    assign ack_seen = !bus.async_transfer_ack_n;
    // selecting at a count up to this one still lands before the rise (best five clocks, worst one)
    assign early_enough = cnt_reg <= SYNC_LAST_CNT;

    // next-state logic of the bus cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (i_start) begin
                    state_next = ST_S0;
                end
            end
            ST_S0: state_next = ST_S1;
            ST_S1: state_next = ST_S2;
            ST_S2: state_next = ST_S3;
            ST_S3: state_next = ST_S4;
            ST_S4, ST_WAIT: begin
                // s4 is the earliest point the request counts; the request wins over
                // the acknowledge, since both together is an illegal far-end state
                if (req_seen) begin
                    state_next = early_enough ? ST_ALIGN : ST_SYNC;
                end else if (ack_seen) begin
                    state_next = ST_S5; // plain asynchronous completion
                end else begin
                    state_next = ST_WAIT;
                end
            end
            ST_SYNC: begin
                // too late for this phase pulse: wait for a low window early enough
                if (early_enough) begin
                    state_next = ST_ALIGN;
                end
            end
            ST_ALIGN: begin
                // select is out; line s5 up so s6 is the last high clock
                if (cnt_reg == ALIGN_CNT) begin
                    state_next = ST_S5;
                end
            end
            ST_S5: state_next = ST_S6;
            ST_S6: state_next = ST_S7;
            ST_S7: state_next = ST_END;
            ST_END: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= ST_IDLE;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    // capture the request of the user side at the start of a cycle
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            write_reg <= 1'b0;
            addr_reg <= '0;
            fc_reg <= '0;
            be_reg <= '0;
            wdata_reg <= '0;
        end else if (i_ce && state_reg == ST_IDLE && i_start) begin
            write_reg <= i_write;
            addr_reg <= i_addr;
            fc_reg <= i_fc;
            be_reg <= i_byte_en;
            wdata_reg <= i_wdata;
        end
    end

    // sync flag: set when the cycle goes the synchronous way, cleared by a new cycle
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync_reg <= 1'b0;
        end else if (i_ce) begin
            if (state_next == ST_SYNC || state_next == ST_ALIGN) begin
                sync_reg <= 1'b1;
            end else if (state_next == ST_S0) begin
                sync_reg <= 1'b0;
            end
        end
    end

    // pin flops, each decided from the state being entered so pins change with it
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fc_oe_reg <= 1'b0;
            addr_oe_reg <= 1'b0;
            as_n_reg <= 1'b1;
            ds_on_reg <= 1'b0;
            rw_n_reg <= 1'b1;
            data_oe_reg <= 1'b0;
        end else if (i_ce) begin
            case (state_next)
                ST_IDLE: begin
                    fc_oe_reg <= 1'b0;
                    addr_oe_reg <= 1'b0;
                    as_n_reg <= 1'b1;
                    ds_on_reg <= 1'b0;
                    rw_n_reg <= 1'b1;
                    data_oe_reg <= 1'b0;
                end
                ST_S0: fc_oe_reg <= 1'b1; // address still floating
                ST_S1: addr_oe_reg <= 1'b1;
                ST_S2: begin
                    as_n_reg <= 1'b0;
                    ds_on_reg <= !write_reg; // read strobes go with the address strobe
                    rw_n_reg <= !write_reg;
                end
                ST_S3: data_oe_reg <= write_reg;
                ST_S4: ds_on_reg <= 1'b1; // write strobes mark valid data
                ST_S7: begin
                    as_n_reg <= 1'b1;
                    ds_on_reg <= 1'b0;
                end
                ST_END: begin
                    addr_oe_reg <= 1'b0;
                    rw_n_reg <= 1'b1;
                    data_oe_reg <= 1'b0;
                    fc_oe_reg <= 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    // select: low only once the request is seen and the phase is known low
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sel_n_reg <= 1'b1; // idle high, so a floated bus never selects
        end else if (i_ce) begin
            if (state_next == ST_ALIGN) begin
                sel_n_reg <= 1'b0;
            end else if (state_next == ST_S7 || state_next == ST_IDLE) begin
                sel_n_reg <= 1'b1;
            end
        end
    end

    // read data latched in s6 while the phase is still high
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_reg <= '0;
        end else if (i_ce && state_reg == ST_S6 && !write_reg) begin
            rdata_reg <= bus.data_bus;
        end
    end

    // completion pulse when the bus is released
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            done_reg <= 1'b0;
        end else if (i_ce) begin
            done_reg <= (state_next == ST_END);
        end else begin
            done_reg <= 1'b0; // a frozen clock must not stretch the pulse
        end
    end

    assign bus.phase_clk = phase_reg;
    assign bus.addr = addr_reg;
    assign bus.addr_oe = addr_oe_reg;
    assign bus.fc = fc_reg;
    assign bus.fc_oe = fc_oe_reg;
    assign bus.cpu_data = wdata_reg;
    assign bus.cpu_data_oe = data_oe_reg;
    assign bus.rw_n = rw_n_reg;
    assign bus.address_valid_strobe_n = as_n_reg;
    assign bus.upper_byte_strobe_n = !(ds_on_reg && be_reg[1]);
    assign bus.lower_byte_strobe_n = !(ds_on_reg && be_reg[0]);
    assign bus.valid_peripheral_select_n = sel_n_reg;
    assign o_busy = (state_reg != ST_IDLE);
    assign o_done = done_reg;
    assign o_sync_cycle = sync_reg;
    assign o_rdata = rdata_reg;
endmodule // spb_cpu_end

// ===== spb_checker.sv
// concurrent checks on the pins between the processor end and the peripheral end
`timescale 1ns/1ps
module spb_checker (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce, // low freezes the design, so every span stretches
    input wire logic phase_clk,
    input wire logic addr_oe,
    input wire logic fc_oe,
    input wire logic cpu_data_oe,
    input wire logic rw_n,
    input wire logic address_valid_strobe_n,
    input wire logic upper_byte_strobe_n,
    input wire logic lower_byte_strobe_n,
    input wire logic sync_device_request_n,
    input wire logic async_transfer_ack_n,
    input wire logic valid_peripheral_select_n
);
    // one domain, so one clock and one reset for every property
    default clocking cb @(posedge i_clk);
    endclocking
    // a frozen clock enable stretches spans legally, so checks pause with it
    default disable iff (i_sys_rst || !i_ce);
    phase_low_span_a: assert property ($fell(phase_clk) |-> (!phase_clk) [*6] ##1 phase_clk)
        else $error("phase clock low span wrong");
    phase_high_span_a: assert property ($rose(phase_clk) |-> phase_clk [*4] ##1 !phase_clk)
        else $error("phase clock high span wrong");
    // address first, then strobes; the read strobes come with the address strobe
    read_strobe_order_a: assert property ($fell(address_valid_strobe_n) && rw_n |->
        !(upper_byte_strobe_n && lower_byte_strobe_n) && $past(addr_oe) && !$past(addr_oe, 2)
        && $past(fc_oe, 2)) else $error("read strobe order wrong");
    write_order_a: assert property ($fell(rw_n) |-> !address_valid_strobe_n
        && upper_byte_strobe_n && lower_byte_strobe_n ##1 cpu_data_oe && upper_byte_strobe_n
        ##1 !(upper_byte_strobe_n && lower_byte_strobe_n)) else $error("write order wrong");
    // select only once the phase clock is low and the request stands
    select_start_a: assert property ($fell(valid_peripheral_select_n) |-> !phase_clk
        && !sync_device_request_n && !address_valid_strobe_n ##[1:5] $rose(phase_clk))
        else $error("select asserted out of step");
    strobe_negate_a: assert property ($rose(address_valid_strobe_n)
        && $past(!valid_peripheral_select_n) |-> $fell(phase_clk) && valid_peripheral_select_n
        && upper_byte_strobe_n && lower_byte_strobe_n) else $error("strobes not negated in s7");
    bus_release_a: assert property ($rose(address_valid_strobe_n) |=>
        !addr_oe && rw_n && !fc_oe && !cpu_data_oe) else $error("bus not released after s7");
    select_needs_strobe_a: assert property (address_valid_strobe_n |-> valid_peripheral_select_n)
        else $error("select active without address strobe");
    request_drop_a: assert property ($rose(address_valid_strobe_n) |-> ##[0:1] sync_device_request_n)
        else $error("request held after strobe");
    ack_exclusive_a: assert property (!sync_device_request_n |-> async_transfer_ack_n)
        else $error("ack with request active");
endmodule // spb_checker

// ===== tb.sv
// top bench: both bus ends joined, user side driven by cycle tasks
`timescale 1ns/1ps
module tb;
    import spb_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1; // held for the first two clocks
    logic i_ce = 1'b1;
    logic i_start = 1'b0;
    logic i_write = 1'b0;
    logic [ADDR_W-1:0] i_addr = 24'h000000;
    logic [FC_W-1:0] i_fc = 3'h5;
    logic [1:0] i_byte_en = 2'h3;
    logic [DATA_W-1:0] i_wdata = 16'h0000;
    logic i_use_ext_select = 1'b0; // start on the processor select pin
    logic o_busy, o_done, o_sync_cycle, o_selected, o_write_seen;
    logic [DATA_W-1:0] o_rdata;
    logic ext_seen = 1'b0; // sticky flags, observed at the falling edge
    logic sel_seen = 1'b0;
    logic wr_seen = 1'b0;
    logic phase_prev = 1'b0;
    logic ph;
    int phase_age = 0; // clocks since the phase clock last fell
    int bad_count = 0;
    int n_compared = 0;
    spb_if bus_if ();
    spb_cpu_end i_spb_cpu_end (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .bus(bus_if),
        .i_start(i_start), .i_write(i_write), .i_addr(i_addr), .i_fc(i_fc),
        .i_byte_en(i_byte_en), .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done),
        .o_sync_cycle(o_sync_cycle), .o_rdata(o_rdata));
    spb_peripheral_end i_spb_peripheral_end (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
        .bus(bus_if), .i_use_ext_select(i_use_ext_select), .o_selected(o_selected),
        .o_write_seen(o_write_seen));
    spb_checker i_spb_checker (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
        .phase_clk(bus_if.phase_clk), .addr_oe(bus_if.addr_oe), .fc_oe(bus_if.fc_oe),
        .cpu_data_oe(bus_if.cpu_data_oe), .rw_n(bus_if.rw_n),
        .address_valid_strobe_n(bus_if.address_valid_strobe_n),
        .upper_byte_strobe_n(bus_if.upper_byte_strobe_n),
        .lower_byte_strobe_n(bus_if.lower_byte_strobe_n),
        .sync_device_request_n(bus_if.sync_device_request_n),
        .async_transfer_ack_n(bus_if.async_transfer_ack_n),
        .valid_peripheral_select_n(bus_if.valid_peripheral_select_n));
    // 50 ns period
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    // monitors sample at the falling edge, where outputs are settled
    always @(negedge i_clk) begin
        phase_prev <= bus_if.phase_clk;
        phase_age <= (phase_prev && !bus_if.phase_clk) ? 0 : phase_age + 1;
        if (o_selected === 1'b1 && i_use_ext_select) ext_seen <= 1'b1;
        if (o_selected === 1'b1) sel_seen <= 1'b1;
        if (o_write_seen === 1'b1) wr_seen <= 1'b1;
    end
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one whole bus cycle; the user request is taken only while idle
    task automatic run_cycle(input logic wr, input logic [ADDR_W-1:0] a,
            input logic [1:0] be, input logic [DATA_W-1:0] wd);
        int n;
        n = 0;
        while (o_busy !== 1'b0) @(negedge i_clk);
        i_write = wr;
        i_addr = a;
        i_byte_en = be;
        i_wdata = wd;
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        while (o_done !== 1'b1 && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        check(16'(o_done), 16'h0001);
        check(16'({bus_if.fc, bus_if.addr[7:0]}), 16'({i_fc, a[7:0]}));
        // end state: one clock after the phase fall, bus released, cycle marked synchronous
        check(16'({o_sync_cycle, bus_if.rw_n, bus_if.addr_oe, bus_if.cpu_data_oe,
            phase_age == 0}), 16'h0019);
    endtask
    task automatic complete_run();
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // watchdog: the sequence needs well under 2000 clocks
    initial begin
        #200000;
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end
    initial begin
        repeat (2) @(negedge i_clk);
        i_sys_rst = 1'b0;
        run_cycle(1'b1, 24'hff0002, 2'h3, 16'h1234);
        run_cycle(1'b0, 24'hff0002, 2'h3, 16'h0000);
        check(o_rdata, 16'h1234);
        check(16'({wr_seen, sel_seen}), 16'h0003);
        $display("test word transfer done");
        // lane writes: only the strobed byte may change
        run_cycle(1'b1, 24'hff0004, 2'h3, 16'h5555);
        run_cycle(1'b1, 24'hff0004, 2'h2, 16'haa00);
        run_cycle(1'b1, 24'hff0006, 2'h3, 16'h5555);
        run_cycle(1'b1, 24'hff0006, 2'h1, 16'h00aa);
        run_cycle(1'b0, 24'hff0004, 2'h3, 16'h0000);
        check(o_rdata, 16'haa55);
        run_cycle(1'b0, 24'hff0006, 2'h3, 16'h0000);
        check(o_rdata, 16'h55aa);
        $display("test byte lanes done");
        // start at nine of the ten phase offsets; offsets zero and one both start back to back
        for (int i = 0; i < 10; i++) begin
            repeat (i) @(negedge i_clk);
            run_cycle(1'b0, 24'hff0002, 2'h3, 16'h0000);
            check(o_rdata, 16'h1234);
        end
        $display("test phase sweep done");
        // peripheral chip select built from the two-stage external logic
        i_use_ext_select = 1'b1;
        run_cycle(1'b1, 24'hff0008, 2'h3, 16'hc3c3);
        run_cycle(1'b0, 24'hff0008, 2'h3, 16'h0000);
        check(o_rdata, 16'hc3c3);
        repeat (2) @(negedge i_clk);
        check(16'(ext_seen), 16'h0001);
        check(16'(i_spb_peripheral_end.ext_select), 16'h0000);
        i_use_ext_select = 1'b0;
        $display("test external select done");
        // a frozen clock enable stops the divider too
        ph = bus_if.phase_clk;
        i_ce = 1'b0;
        repeat (4) @(negedge i_clk);
        check(16'(bus_if.phase_clk), 16'(ph));
        i_ce = 1'b1;
        // reset in mid-run: select released high, phase low
        i_sys_rst = 1'b1;
        @(negedge i_clk);
        check(16'({bus_if.valid_peripheral_select_n, bus_if.rw_n, bus_if.phase_clk,
            bus_if.address_valid_strobe_n}), 16'h000d);
        i_sys_rst = 1'b0;
        run_cycle(1'b1, 24'hff000a, 2'h3, 16'h0f0f);
        run_cycle(1'b0, 24'hff000a, 2'h3, 16'h0000);
        check(o_rdata, 16'h0f0f);
        $display("test reset recovery done");
        complete_run();
    end
endmodule // tb
